// *** src/fdc_apd_pkg.sv ***
// package for the floppy auto powerdown block: offsets, fields, timing, types
// assumes a 100 MHz core clock and an 8-bit host register port
// What this block does
// - reset wake runs the full reset sequence
// - register wake keeps all controller state
// - motor bit write wakes; output port read not
// - main status read wakes the controller
// - fifo data read or write wakes
// - after wake, reload 10 ms timer
// - other reads/writes never wake; reads true status
// - writes in powerdown are kept
// - plain output/rate writes stay asleep
// - non-waking access leaves low power unchanged
// - host inputs watched; irq and dma low
// - drive motor/select/write pins tristated asleep
// - uart auto and direct power bits
// - transmitter sleeps when holding and shift empty
// - receiver sleeps when fifo empty, idle
// - ring interrupt works while uart sleeps
// - tx write or rx line change wakes
// - parallel port auto and direct power bits
// - epp sleeps when disabled or unselected
// - ecp sleeps when disabled or in spp, ps2 or epp mode
// - parallel power re-evaluated on mode change
// - sleep needs motors off, idle, timers expired
// - main status read or fifo access restarts timer
// - auto enable bit; clear cancels timer
package fdc_apd_pkg;
   localparam logic [2:0] OFS_STATUS_A = 3'h0;
   localparam logic [2:0] OFS_STATUS_B = 3'h1;
   localparam logic [2:0] OFS_DOUT     = 3'h2;
   localparam logic [2:0] OFS_RATE_MS  = 3'h4;
   localparam logic [2:0] OFS_FIFO     = 3'h5;
   localparam logic [2:0] OFS_DIN_CCR  = 3'h7;
   localparam int DOUT_SEL_LSB  = 0;
   localparam int DOUT_NRST_BIT = 2;
   localparam int DOUT_MOT_LSB  = 4;
   localparam int RATE_SWRST_BIT = 7;
   localparam int AUTO_FDC_BIT  = 7;
   localparam int AUTO_UART2_BIT = 6;
   localparam int AUTO_UART1_BIT = 5;
   localparam int AUTO_PAR_BIT  = 4;
   localparam int UART1_PWR_BIT = 3;
   localparam int UART2_PWR_BIT = 7;
   localparam int PAR_PWR_BIT   = 2;
   localparam logic [7:0] MSR_IDLE  = 8'h80;
   localparam logic [7:0] DOUT_RST  = 8'h00;
   localparam logic [7:0] RATE_RST  = 8'h02;
   localparam logic [2:0] ECR_SPP   = 3'h0;
   localparam logic [2:0] ECR_PS2   = 3'h1;
   localparam logic [2:0] ECR_EPP   = 3'h4;
   localparam int PD_TIME_MS = 10;
   localparam int CLK_MHZ    = 100;
   localparam int PD_CYCLES  = PD_TIME_MS * 1000 * CLK_MHZ;
   localparam int TMR_W      = 20;
   typedef enum logic {FDC_AWAKE, FDC_ASLEEP} fdc_state_t;
   typedef struct packed {
      logic [3:0] motor;
      logic [3:0] select;
      logic       wdata;
      logic       wgate;
   } fdd_tri_t;
   typedef struct packed {
      logic [1:0] hold_empty;
      logic [1:0] shift_empty;
      logic [1:0] rx_fifo_empty;
      logic [1:0] rx_idle;
      logic [1:0] tx_buf_write;
   } uart_stat_t;
endpackage

// *** src/floppy_auto_powerdown.sv ***
// floppy, uart and parallel port auto powerdown control
// assumes one-cycle synchronous host strobes; core halts when not run
`timescale 1ns/1ps
module floppy_auto_powerdown #(
   parameter int PD_TIMER_CYCLES = fdc_apd_pkg::PD_CYCLES
) (
   input  wire logic                    core_clk_i,
   input  wire logic                    sys_rst_i,
   input  wire logic                    io_rd_i,
   input  wire logic                    io_wr_i,
   input  wire logic [2:0]              addr_i,
   input  wire logic [7:0]              wdata_i,
   input  wire logic [7:0]              status_a_i,
   input  wire logic [7:0]              status_b_i,
   input  wire logic [7:0]              core_msr_i,
   input  wire logic [7:0]              core_fifo_rdata_i,
   input  wire logic [7:0]              din_i,
   input  wire logic                    core_int_i,
   input  wire logic                    core_drq_i,
   input  wire logic                    head_unload_done_i,
   input  wire logic                    core_wdata_i,
   input  wire logic                    core_wgate_i,
   input  wire logic                    core_step_i,
   input  wire logic                    core_step_dir_i,
   input  wire logic                    core_head_i,
   input  wire logic                    core_density_i,
   input  wire logic [7:0]              auto_power_config_i,
   input  wire logic [7:0]              uart_power_config_i,
   input  wire logic [7:0]              parport_power_config_i,
   input  wire fdc_apd_pkg::uart_stat_t uart_stat_i,
   input  wire logic [1:0]              uart_serial_in_i,
   input  wire logic [1:0]              phone_bell_in_i,
   input  wire logic [1:0]              ring_ack_i,
   input  wire logic                    epp_enabled_i,
   input  wire logic                    ecp_enabled_i,
   input  wire logic [2:0]              ecr_mode_i,
   output logic [7:0]                   rdata_o,
   output logic                         fifo_rd_o,
   output logic                         fifo_wr_o,
   output logic [7:0]                   fifo_wdata_o,
   output logic                         core_reset_o,
   output logic                         core_run_o,
   output logic                         floppy_irq_out_o,
   output logic                         floppy_dma_request_o,
   output fdc_apd_pkg::fdd_tri_t        fdd_out_o,
   output fdc_apd_pkg::fdd_tri_t        fdd_oe_o,
   output logic                         step_o,
   output logic                         step_dir_o,
   output logic                         head_side_select_o,
   output logic                         density_select_o,
   output logic [1:0]                   rate_select_out_o,
   output logic [1:0]                   uart_tx_pd_o,
   output logic [1:0]                   uart_rx_pd_o,
   output logic [1:0]                   uart_ring_irq_o,
   output logic                         epp_pd_o,
   output logic                         ecp_pd_o
);

   localparam logic [fdc_apd_pkg::TMR_W-1:0] TMR_LOAD =
      fdc_apd_pkg::TMR_W'(PD_TIMER_CYCLES);

   fdc_apd_pkg::fdc_state_t      state_reg;
   fdc_apd_pkg::fdc_state_t      state_next;
   logic [fdc_apd_pkg::TMR_W-1:0] tmr_reg;
   logic [fdc_apd_pkg::TMR_W-1:0] tmr_next;
   logic [7:0]                   dout_reg;
   logic [7:0]                   rate_reg;
   logic [1:0]                   speed_reg;
   logic                         soft_rst_reg;
   logic [1:0]                   rx_last_reg;
   logic [1:0]                   ring_last_reg;
   logic [1:0]                   ring_flag_reg;
   logic [1:0]                   tx_pd_reg;
   logic [1:0]                   rx_pd_reg;

   logic wr_dout;
   logic wr_rate;
   logic wr_ccr;
   logic rd_msr;
   logic acc_fifo;
   logic soft_rst;
   logic motor_wake;
   logic wake;
   logic restart;
   logic auto_en;
   logic idle_ok;
   logic [1:0] uart_auto;
   logic [1:0] uart_on;
   logic [1:0] rx_change;
   logic par_auto;
   logic par_on;

   // address decode
   function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs);
      return a == ofs;
   endfunction

   always_comb begin
      wr_dout  = io_wr_i && hit(addr_i, fdc_apd_pkg::OFS_DOUT);
      wr_rate  = io_wr_i && hit(addr_i, fdc_apd_pkg::OFS_RATE_MS);
      wr_ccr   = io_wr_i && hit(addr_i, fdc_apd_pkg::OFS_DIN_CCR);
      rd_msr   = io_rd_i && hit(addr_i, fdc_apd_pkg::OFS_RATE_MS);
      acc_fifo = (io_rd_i || io_wr_i) && hit(addr_i, fdc_apd_pkg::OFS_FIFO);
   end

   // wake sources
   always_comb begin
      soft_rst = (wr_dout && !wdata_i[fdc_apd_pkg::DOUT_NRST_BIT])
              || (wr_rate && wdata_i[fdc_apd_pkg::RATE_SWRST_BIT]);
      motor_wake = wr_dout && (wdata_i[7:fdc_apd_pkg::DOUT_MOT_LSB] != 4'h0);
      wake = soft_rst || motor_wake || rd_msr || acc_fifo;
      restart = rd_msr || acc_fifo;
      auto_en = auto_power_config_i[fdc_apd_pkg::AUTO_FDC_BIT];
      idle_ok = (dout_reg[7:fdc_apd_pkg::DOUT_MOT_LSB] == 4'h0)
             && (core_msr_i == fdc_apd_pkg::MSR_IDLE)
             && !core_int_i
             && head_unload_done_i;
   end

   // floppy power state
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         fdc_apd_pkg::FDC_AWAKE: begin
            if (auto_en && !wake && idle_ok && tmr_reg == '0) begin
               state_next = fdc_apd_pkg::FDC_ASLEEP;
            end
         end
         fdc_apd_pkg::FDC_ASLEEP: begin
            if (!auto_en || wake) begin
               state_next = fdc_apd_pkg::FDC_AWAKE;
            end
            // other accesses leave the state alone
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_reg <= fdc_apd_pkg::FDC_AWAKE;
      end else begin
         state_reg <= state_next;
      end
   end

   // powerdown timer
   always_comb begin
      tmr_next = tmr_reg;
      if (!auto_en) begin
         tmr_next = TMR_LOAD;
      end else if (state_reg == fdc_apd_pkg::FDC_ASLEEP) begin
         tmr_next = TMR_LOAD;
      end else if (restart) begin
         tmr_next = TMR_LOAD;
      end else if (tmr_reg != '0) begin
         tmr_next = tmr_reg - 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tmr_reg <= TMR_LOAD;
      end else begin
         tmr_reg <= tmr_next;
      end
   end

   // host registers, written in any power state
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dout_reg <= fdc_apd_pkg::DOUT_RST;
      end else if (wr_dout) begin
         dout_reg <= wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rate_reg <= fdc_apd_pkg::RATE_RST;
      end else if (wr_rate) begin
         rate_reg <= wdata_i;
      end
   end

   // data rate from last rate or config control write
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         speed_reg <= fdc_apd_pkg::RATE_RST[1:0];
      end else if (wr_rate || wr_ccr) begin
         speed_reg <= wdata_i[1:0];
      end
   end

   // soft reset into the core: one-cycle pulse on a rate reset, held while the output port reset bit is low
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         soft_rst_reg <= 1'b0;
      end else begin
         soft_rst_reg <= soft_rst;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         core_reset_o <= 1'b1;
      end else begin
         core_reset_o <= soft_rst_reg || !dout_reg[fdc_apd_pkg::DOUT_NRST_BIT];
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         core_run_o <= 1'b1;
      end else begin
         core_run_o <= state_next == fdc_apd_pkg::FDC_AWAKE;
      end
   end

   // reads show live status
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rdata_o <= 8'h00;
      end else if (io_rd_i) begin
         unique case (addr_i)
            fdc_apd_pkg::OFS_STATUS_A: rdata_o <= status_a_i;
            fdc_apd_pkg::OFS_STATUS_B: rdata_o <= status_b_i;
            fdc_apd_pkg::OFS_DOUT:     rdata_o <= dout_reg;
            fdc_apd_pkg::OFS_RATE_MS:  rdata_o <= core_msr_i;
            fdc_apd_pkg::OFS_FIFO:     rdata_o <= core_fifo_rdata_i;
            fdc_apd_pkg::OFS_DIN_CCR:  rdata_o <= din_i;
            default:                   rdata_o <= 8'h00;
         endcase
      end
   end

   // fifo strobes pass to the core
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fifo_rd_o    <= 1'b0;
         fifo_wr_o    <= 1'b0;
         fifo_wdata_o <= 8'h00;
      end else begin
         fifo_rd_o <= acc_fifo && io_rd_i;
         fifo_wr_o <= acc_fifo && io_wr_i;
         if (acc_fifo && io_wr_i) begin
            fifo_wdata_o <= wdata_i;
         end
      end
   end

   // host outputs held low while asleep
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         floppy_irq_out_o     <= 1'b0;
         floppy_dma_request_o <= 1'b0;
      end else begin
         floppy_irq_out_o     <= core_int_i && state_next == fdc_apd_pkg::FDC_AWAKE;
         floppy_dma_request_o <= core_drq_i && state_next == fdc_apd_pkg::FDC_AWAKE;
      end
   end

   // drive pins: some tristated asleep, the rest stay active
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         fdd_out_o <= '0;
         fdd_oe_o  <= '1;
      end else begin
         fdd_out_o.motor  <= dout_reg[7:fdc_apd_pkg::DOUT_MOT_LSB];
         fdd_out_o.select <= 4'h1 << dout_reg[fdc_apd_pkg::DOUT_SEL_LSB +: 2];
         fdd_out_o.wdata  <= core_wdata_i;
         fdd_out_o.wgate  <= core_wgate_i;
         fdd_oe_o <= (state_next == fdc_apd_pkg::FDC_AWAKE) ? '1 : '0;
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         step_o             <= 1'b0;
         step_dir_o         <= 1'b0;
         head_side_select_o <= 1'b0;
         density_select_o   <= 1'b0;
         rate_select_out_o  <= fdc_apd_pkg::RATE_RST[1:0];
      end else begin
         step_o             <= core_step_i;
         step_dir_o         <= core_step_dir_i;
         head_side_select_o <= core_head_i;
         density_select_o   <= core_density_i;
         rate_select_out_o  <= speed_reg;
      end
   end

   // uart power control
   always_comb begin
      uart_auto[0] = auto_power_config_i[fdc_apd_pkg::AUTO_UART1_BIT];
      uart_auto[1] = auto_power_config_i[fdc_apd_pkg::AUTO_UART2_BIT];
      uart_on[0]   = uart_power_config_i[fdc_apd_pkg::UART1_PWR_BIT];
      uart_on[1]   = uart_power_config_i[fdc_apd_pkg::UART2_PWR_BIT];
      rx_change    = uart_serial_in_i ^ rx_last_reg;
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         rx_last_reg   <= 2'h3;
         ring_last_reg <= 2'h0;
      end else begin
         rx_last_reg   <= uart_serial_in_i;
         ring_last_reg <= phone_bell_in_i;
      end
   end

   // ring change flag, kept while asleep; set beats ack
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ring_flag_reg <= 2'h0;
      end else begin
         ring_flag_reg <= (ring_flag_reg & ~ring_ack_i)
                        | (phone_bell_in_i ^ ring_last_reg);
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         tx_pd_reg <= 2'h0;
         rx_pd_reg <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (!uart_auto[i]) begin
               tx_pd_reg[i] <= 1'b0;
               rx_pd_reg[i] <= 1'b0;
            end else begin
               if (uart_stat_i.tx_buf_write[i]) begin
                  tx_pd_reg[i] <= 1'b0;
               end else if (uart_stat_i.hold_empty[i] && uart_stat_i.shift_empty[i]) begin
                  tx_pd_reg[i] <= 1'b1;
               end
               if (rx_change[i]) begin
                  rx_pd_reg[i] <= 1'b0;
               end else if (uart_stat_i.rx_fifo_empty[i] && uart_stat_i.rx_idle[i]) begin
                  rx_pd_reg[i] <= 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         uart_tx_pd_o    <= 2'h0;
         uart_rx_pd_o    <= 2'h0;
         uart_ring_irq_o <= 2'h0;
      end else begin
         uart_tx_pd_o    <= tx_pd_reg | ~uart_on;
         uart_rx_pd_o    <= rx_pd_reg | ~uart_on;
         uart_ring_irq_o <= ring_flag_reg;
      end
   end

   // parallel port power, re-evaluated every cycle
   always_comb begin
      par_auto = auto_power_config_i[fdc_apd_pkg::AUTO_PAR_BIT];
      par_on   = parport_power_config_i[fdc_apd_pkg::PAR_PWR_BIT];
   end

   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         epp_pd_o <= 1'b0;
         ecp_pd_o <= 1'b0;
      end else begin
         epp_pd_o <= !par_on || (par_auto && (!epp_enabled_i
                  || (ecp_enabled_i && ecr_mode_i != fdc_apd_pkg::ECR_EPP)));
         ecp_pd_o <= !par_on || (par_auto && (!ecp_enabled_i
                  || ecr_mode_i == fdc_apd_pkg::ECR_SPP
                  || ecr_mode_i == fdc_apd_pkg::ECR_PS2
                  || ecr_mode_i == fdc_apd_pkg::ECR_EPP));
      end
   end

endmodule

// *** dv/floppy_auto_powerdown_checker.sv ***
// assertions on the floppy auto powerdown ports
// assumes one clock and a bind from the bench top
`timescale 1ns/1ps
module floppy_auto_powerdown_checker #(
   parameter int PD_TIMER_CYCLES = 20
) (
   input wire logic                 core_clk_i,
   input wire logic                 sys_rst_i,
   input wire logic                 io_rd_i,
   input wire logic                 io_wr_i,
   input wire logic [2:0]           addr_i,
   input wire logic [7:0]           wdata_i,
   input wire logic [7:0]           core_msr_i,
   input wire logic                 core_int_i,
   input wire logic                 head_unload_done_i,
   input wire logic [7:0]           auto_power_config_i,
   input wire logic [7:0]           parport_power_config_i,
   input wire logic                 epp_enabled_i,
   input wire logic                 ecp_enabled_i,
   input wire logic [2:0]           ecr_mode_i,
   input wire logic [1:0]           phone_bell_in_i,
   input wire logic                 core_run_o,
   input wire logic                 floppy_irq_out_o,
   input wire logic                 floppy_dma_request_o,
   input wire fdc_apd_pkg::fdd_tri_t fdd_oe_o,
   input wire logic [1:0]           uart_ring_irq_o,
   input wire logic                 epp_pd_o,
   input wire logic                 ecp_pd_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic        slp;
   logic        kick;
   logic        quiet;
   logic        par_on;
   logic [31:0] awake_cnt_reg;
   assign slp = !core_run_o;
   assign par_on = auto_power_config_i[4] && parport_power_config_i[2];
   // timer restart accesses
   assign kick = (io_rd_i && addr_i == 3'h4) || ((io_rd_i || io_wr_i) && addr_i == 3'h5);
   assign quiet = auto_power_config_i[7] && ((io_rd_i && addr_i inside {3'h0, 3'h1, 3'h2, 3'h7})
      || (io_wr_i && addr_i == 3'h7) || (io_wr_i && addr_i == 3'h4 && !wdata_i[7])
      || (io_wr_i && addr_i == 3'h2 && wdata_i[7:4] == 4'h0 && wdata_i[2]));
   // awake cycles since restart
   always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) awake_cnt_reg <= '0;
      else if (slp || kick || !auto_power_config_i[7]) awake_cnt_reg <= '0;
      else if (awake_cnt_reg < 32'hffff) awake_cnt_reg <= awake_cnt_reg + 32'h1;
   end
   sequence s_kick_asleep; slp && kick; endsequence
   sequence s_epp_off; (par_on && !epp_enabled_i) [*2]; endsequence
   sequence s_ecp_off;
      (par_on && ecp_enabled_i && ecr_mode_i inside {3'h0, 3'h1, 3'h4}) [*2];
   endsequence
   property p_irq_low; slp |-> !floppy_irq_out_o && !floppy_dma_request_o; endproperty
   property p_tristate; slp |-> fdd_oe_o == '0; endproperty
   property p_kick_wake; s_kick_asleep |-> ##[1:2] core_run_o; endproperty
   property p_motor_wake;
      slp && io_wr_i && addr_i == 3'h2 && wdata_i[7:4] != 4'h0 |-> ##[1:2] core_run_o;
   endproperty
   property p_quiet; slp && quiet |=> slp; endproperty
   property p_entry;
      $fell(core_run_o) |-> $past(auto_power_config_i[7] && core_msr_i == 8'h80
         && !core_int_i && head_unload_done_i);
   endproperty
   property p_timer; $fell(core_run_o) |-> awake_cnt_reg >= PD_TIMER_CYCLES - 1; endproperty
   property p_epp; s_epp_off |-> epp_pd_o; endproperty
   property p_ecp; s_ecp_off |-> ecp_pd_o; endproperty
   property p_ring; $changed(phone_bell_in_i[0]) |-> ##[1:3] uart_ring_irq_o[0]; endproperty
   a_irq_low: assert property (p_irq_low) else $error("irq or dma high asleep");
   a_tristate: assert property (p_tristate) else $error("drive pins on asleep");
   a_kick_wake: assert property (p_kick_wake) else $error("no wake on access");
   a_motor_wake: assert property (p_motor_wake) else $error("no motor wake");
   a_quiet: assert property (p_quiet) else $error("woke on quiet access");
   a_entry: assert property (p_entry) else $error("slept while not idle");
   a_timer: assert property (p_timer) else $error("slept too early");
   a_epp: assert property (p_epp) else $error("epp awake");
   a_ecp: assert property (p_ecp) else $error("ecp awake");
   a_ring: assert property (p_ring) else $error("ring flag missing");
endmodule

// *** dv/floppy_core_model.sv ***
// controller core stand-in: idle status, one-byte fifo
// assumes bench drives busy_i; fifo strobes one cycle
`timescale 1ns/1ps
module floppy_core_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       busy_i,
   input  wire logic       fifo_wr_i,
   input  wire logic [7:0] fifo_wdata_i,
   output logic [7:0]      msr_o,
   output logic [7:0]      fifo_rdata_o,
   output logic            int_o,
   output logic            drq_o,
   output logic            head_done_o
);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) fifo_rdata_o <= 8'h00;
      else if (fifo_wr_i) fifo_rdata_o <= fifo_wdata_i;
   end
   // busy: not idle, irq and dma up, head loaded
   assign msr_o = busy_i ? 8'h10 : 8'h80;
   assign int_o = busy_i;
   assign drq_o = busy_i;
   assign head_done_o = !busy_i;
endmodule

// *** dv/floppy_auto_powerdown_test.sv ***
// bench for the floppy auto powerdown block: register tasks and tests
// assumes checker and core model compiled first
`timescale 1ns/1ps
module floppy_auto_powerdown_test;
   localparam int PD = 20;
   logic core_clk_i, sys_rst_i, io_rd_i, io_wr_i, core_int_i, core_drq_i, head_unload_done_i;
   logic core_wdata_i, core_wgate_i, core_step_i, core_step_dir_i, core_head_i, core_density_i;
   logic epp_enabled_i, ecp_enabled_i, busy, fifo_rd_o, fifo_wr_o, core_reset_o, core_run_o;
   logic floppy_irq_out_o, floppy_dma_request_o, step_o, step_dir_o, head_side_select_o;
   logic density_select_o, epp_pd_o, ecp_pd_o, rst_seen, f;
   logic [2:0] addr_i, ecr_mode_i;
   logic [7:0] wdata_i, status_a_i, status_b_i, core_msr_i, core_fifo_rdata_i, din_i, rd;
   logic [7:0] auto_power_config_i, uart_power_config_i, parport_power_config_i;
   logic [7:0] rdata_o, fifo_wdata_o;
   logic [1:0] uart_serial_in_i, phone_bell_in_i, ring_ack_i, rate_select_out_o;
   logic [1:0] uart_tx_pd_o, uart_rx_pd_o, uart_ring_irq_o;
   fdc_apd_pkg::uart_stat_t uart_stat_i;
   fdc_apd_pkg::fdd_tri_t   fdd_out_o, fdd_oe_o;
   int n_errors = 0, n_compared = 0, k;
   logic [11:0] wt[5] = '{12'hd5a, 12'h500, 12'ha14, 12'hc80, 12'ha00};
   logic [2:0]  qa[4] = '{3'h0, 3'h1, 3'h2, 3'h7};
   logic [7:0]  qe[4] = '{8'h3c, 8'hc3, 8'h04, 8'h81};
   logic [6:0]  pt[5] = '{7'b0110011, 7'b1110001, 7'b1100011, 7'b1100111, 7'b1101110};
   floppy_auto_powerdown #(.PD_TIMER_CYCLES(PD)) uut (.*);
   floppy_core_model core_m (.clk_i(core_clk_i), .rst_i(sys_rst_i), .busy_i(busy),
      .fifo_wr_i(fifo_wr_o), .fifo_wdata_i(fifo_wdata_o), .msr_o(core_msr_i),
      .fifo_rdata_o(core_fifo_rdata_i), .int_o(core_int_i), .drq_o(core_drq_i),
      .head_done_o(head_unload_done_i));
   always #5 core_clk_i = !core_clk_i;
   always @(posedge core_clk_i) if (core_reset_o === 1'b1) rst_seen <= 1'b1;
   task automatic complete_run;
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask
   task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      io_wr_i <= w;
      io_rd_i <= !w;
      addr_i  <= a;
      wdata_i <= d;
      @(posedge core_clk_i);
      io_wr_i <= 1'b0;
      io_rd_i <= 1'b0;
      #1 rd = rdata_o;
   endtask
   task automatic sleep_wait;
      for (k = 0; core_run_o !== 1'b0 && k < 200; k++) cyc(1);
      chk(core_run_o, 1'b0);
   endtask
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_errors++;
      complete_run();
   end
   initial begin
      {core_clk_i, io_rd_i, io_wr_i, addr_i, wdata_i, busy, ring_ack_i, phone_bell_in_i} = '0;
      {core_wdata_i, core_wgate_i, core_step_i, core_step_dir_i, core_head_i} = '0;
      {core_density_i, uart_stat_i, rst_seen} = '0;
      {sys_rst_i, epp_enabled_i, ecp_enabled_i, ecr_mode_i, uart_serial_in_i} = '1;
      {status_a_i, status_b_i, din_i} = {8'h3c, 8'hc3, 8'h81};
      {auto_power_config_i, uart_power_config_i, parport_power_config_i} = 24'hf08804;
      repeat (12) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      cyc(1);
      chk(rate_select_out_o, 2'b10);
      chk(core_reset_o, 1'b1);
      acc(1'b0, 3'h2, 8'h00);
      chk(rd, fdc_apd_pkg::DOUT_RST);
      acc(1'b1, 3'h2, 8'h04);
      $display("test reset done");
      sleep_wait();
      chk(fdd_oe_o, '0);
      chk({floppy_irq_out_o, floppy_dma_request_o}, 2'b00);
      @(posedge core_clk_i);
      {core_step_i, core_step_dir_i, core_head_i, core_density_i} <= 4'b1011;
      cyc(2);
      chk({step_o, step_dir_o, head_side_select_o, density_select_o}, 4'b1011);
      for (int i = 0; i < 4; i++) begin
         acc(1'b0, qa[i], 8'h00);
         chk(rd, qe[i]);
         chk(core_run_o, 1'b0);
      end
      acc(1'b1, 3'h7, 8'h03);
      acc(1'b1, 3'h4, 8'h01);
      acc(1'b1, 3'h2, 8'h05);
      chk(core_run_o, 1'b0);
      chk(rate_select_out_o, 2'b01);
      acc(1'b0, 3'h4, 8'h00);
      chk(rd, 8'h80);
      cyc(1);
      chk(core_run_o, 1'b1);
      chk(fdd_oe_o, 10'h3ff);
      acc(1'b0, 3'h2, 8'h00);
      chk(rd, 8'h05);
      chk(fdd_out_o.select, 4'b0010);
      $display("test sleep done");
      acc(1'b0, 3'h4, 8'h00);
      sleep_wait();
      chk(k inside {[PD-2:PD+2]}, 1'b1);
      acc(1'b0, 3'h4, 8'h00);
      cyc(10);
      acc(1'b0, 3'h5, 8'h00);
      sleep_wait();
      chk(k inside {[PD-2:PD+2]}, 1'b1);
      $display("test timer done");
      for (int i = 0; i < 5; i++) begin
         sleep_wait();
         rst_seen = 1'b0;
         acc(wt[i][11], wt[i][10:8], wt[i][7:0]);
         cyc(3);
         chk(core_run_o, 1'b1);
         chk(rst_seen, i > 2);
         acc(1'b1, 3'h2, 8'h04);
      end
      acc(1'b0, 3'h5, 8'h00);
      chk(rd, 8'h5a);
      $display("test wake done");
      @(posedge core_clk_i);
      busy <= 1'b1;
      cyc(3 * PD);
      chk({core_run_o, floppy_irq_out_o}, 2'b11);
      @(posedge core_clk_i);
      busy <= 1'b0;
      sleep_wait();
      acc(1'b1, 3'h2, 8'h24);
      cyc(3 * PD);
      chk(core_run_o, 1'b1);
      chk(fdd_out_o.motor, 4'b0010);
      acc(1'b1, 3'h2, 8'h04);
      sleep_wait();
      @(posedge core_clk_i);
      auto_power_config_i <= 8'h70;
      cyc(3 * PD);
      chk(core_run_o, 1'b1);
      @(posedge core_clk_i);
      auto_power_config_i <= 8'hf0;
      $display("test idle done");
      @(posedge core_clk_i);
      uart_stat_i <= 10'h3fc;
      cyc(3);
      chk({uart_tx_pd_o, uart_rx_pd_o}, 4'hf);
      @(posedge core_clk_i);
      uart_stat_i <= 10'h3dc;
      phone_bell_in_i <= 2'b01;
      cyc(3);
      chk({uart_tx_pd_o, uart_rx_pd_o, uart_ring_irq_o[0]}, 5'b11111);
      @(posedge core_clk_i);
      uart_stat_i <= 10'h2fd;
      ring_ack_i <= 2'b01;
      uart_serial_in_i <= 2'b01;
      f = 1'b0;
      repeat (3) begin
         cyc(1);
         ring_ack_i <= 2'b00;
         f |= uart_rx_pd_o[1] === 1'b0;
      end
      chk({f, uart_tx_pd_o[0], uart_ring_irq_o[0]}, 3'b100);
      @(posedge core_clk_i);
      uart_power_config_i <= 8'h08;
      auto_power_config_i <= 8'hd0;
      cyc(3);
      chk(uart_tx_pd_o, 2'b10);
      $display("test uart done");
      for (int i = 0; i < 5; i++) begin
         @(posedge core_clk_i);
         {epp_enabled_i, ecp_enabled_i, ecr_mode_i} <= pt[i][6:2];
         cyc(3);
         chk({epp_pd_o, ecp_pd_o}, pt[i][1:0]);
      end
      @(posedge core_clk_i);
      parport_power_config_i <= 8'h00;
      cyc(3);
      chk({epp_pd_o, ecp_pd_o}, 2'b11);
      @(posedge core_clk_i);
      {parport_power_config_i, auto_power_config_i} <= 16'h04e0;
      cyc(3);
      chk({epp_pd_o, ecp_pd_o}, 2'b00);
      $display("test parport done");
      complete_run();
   end
endmodule
bind floppy_auto_powerdown floppy_auto_powerdown_checker #(
   .PD_TIMER_CYCLES(PD_TIMER_CYCLES)
) u_chk (.*);
